// File: refsel_pkg.sv
// shared constants, types and helpers for tdm reference selection
package refsel_pkg;

   // ****************************************
   // sizes
   // ****************************************
   localparam int NUM_REF = 4;
   localparam int REF_W = 2;
   localparam int NUM_RANK = 4;
   localparam int NUM_PATH = 2;
   localparam int ENTRY_W = REF_W + 1;
   localparam int TBL_W = NUM_RANK * ENTRY_W;
   localparam int CNT_W = 8;
   localparam int WIN_W = 15;
   localparam int BW_W = 4;

   // path indices: equipment clock path and station clock path
   localparam int PATH_EQ = 0;
   localparam int PATH_ST = 1;

   // ****************************************
   // local oscillator rate codes
   // ****************************************
   localparam logic [1:0] OSC_10M = 2'h0;
   localparam logic [1:0] OSC_12M8 = 2'h1;
   localparam logic [1:0] OSC_20M = 2'h2;
   localparam int OSC_10M_KHZ = 10000;
   localparam int OSC_12M8_KHZ = 12800;
   localparam int OSC_20M_KHZ = 20000;

   // ****************************************
   // timing
   // ****************************************
   // measurement window, microseconds
   localparam int WINDOW_US = 1000;
   localparam int WIN_CYC_10M = WINDOW_US * OSC_10M_KHZ / 1000;
   localparam int WIN_CYC_12M8 = WINDOW_US * OSC_12M8_KHZ / 1000;
   localparam int WIN_CYC_20M = WINDOW_US * OSC_20M_KHZ / 1000;
   // accepted edges per window for an 8 kHz reference
   localparam logic [CNT_W-1:0] EDGE_MIN = 8'h07;
   localparam logic [CNT_W-1:0] EDGE_MAX = 8'h09;
   localparam logic [CNT_W-1:0] EDGE_SAT = 8'hFF;

   // ****************************************
   // reset values
   // ****************************************
   localparam logic [BW_W-1:0] BW_EQ_RST = 4'h1;
   localparam logic [BW_W-1:0] BW_ST_RST = 4'h6;
   localparam logic [TBL_W-1:0] TBL_RST = 12'h000;
   localparam logic [NUM_REF-1:0] EXCL_RST = 4'h0;
   localparam logic [REF_W-1:0] SEL_RST = 2'h0;

   typedef enum logic [1:0] {
      ST_EMPTY = 2'b00,
      ST_LOCK = 2'b01,
      ST_HOLD = 2'b10
   } path_state_t;

   // ****************************************
   // helpers
   // ****************************************
   // {found, index} of the best entry not in bad; rank 0 is highest
   function automatic logic [REF_W:0] pick_ref(
      input logic [TBL_W-1:0] tbl,
      input logic [NUM_REF-1:0] bad);
      logic [REF_W:0] res;
      logic [ENTRY_W-1:0] e;
      res = '0;
      for (int r = NUM_RANK - 1; r >= 0; r--) begin
         e = tbl[r*ENTRY_W +: ENTRY_W];
         if (e[ENTRY_W-1] && !bad[e[REF_W-1:0]]) begin
            res = {1'b1, e[REF_W-1:0]};
         end
      end
      return res;
   endfunction

   // which references appear as valid entries in a table
   function automatic logic [NUM_REF-1:0] tbl_members(
      input logic [TBL_W-1:0] tbl);
      logic [NUM_REF-1:0] m;
      logic [ENTRY_W-1:0] e;
      m = '0;
      for (int r = 0; r < NUM_RANK; r++) begin
         e = tbl[r*ENTRY_W +: ENTRY_W];
         if (e[ENTRY_W-1]) begin
            m[e[REF_W-1:0]] = 1'b1;
         end
      end
      return m;
   endfunction

endpackage

// File: ref_monitor.sv
// activity and frequency monitor for one input reference
`timescale 1ns/1ps
`default_nettype none
module ref_monitor (
   // clock and reset
   input wire logic clk_i,
   input wire logic nrst_i,
   // reference pin and window strobe
   input wire logic ref_i,
   input wire logic win_tick_i,
   // alarms, updated once per window
   output logic inact_o,
   output logic offfreq_o
);
   import refsel_pkg::*;

   logic sync1, sync2, sync3;
   logic [CNT_W-1:0] cnt, next_cnt;
   logic next_inact, next_offfreq;
   logic rise;

   assign rise = sync2 & ~sync3;

   always_comb begin
      next_cnt = cnt;
      next_inact = inact_o;
      next_offfreq = offfreq_o;
      if (win_tick_i) begin
         next_inact = (cnt == '0);
         next_offfreq = (cnt != '0) &&
            ((cnt < EDGE_MIN) || (cnt > EDGE_MAX));
         next_cnt = rise ? CNT_W'(1) : '0;
      end else if (rise && cnt != EDGE_SAT) begin
         next_cnt = cnt + CNT_W'(1);
      end
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         sync1 <= 1'b0;
         sync2 <= 1'b0;
         sync3 <= 1'b0;
         cnt <= '0;
         inact_o <= 1'b0;
         offfreq_o <= 1'b0;
      end else begin
         sync1 <= ref_i;
         sync2 <= sync1;
         sync3 <= sync2;
         cnt <= next_cnt;
         inact_o <= next_inact;
         offfreq_o <= next_offfreq;
      end
   end

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!nrst_i);

   dead_ref_alarm_a: assert property (
      win_tick_i && cnt == '0 |=> inact_o && !offfreq_o)
      else $error("dead reference not flagged inactive");
   off_freq_alarm_a: assert property (
      win_tick_i && cnt > EDGE_MAX |=> offfreq_o && !inact_o)
      else $error("fast reference not flagged off-frequency");
   good_ref_clear_a: assert property (
      win_tick_i && cnt >= EDGE_MIN && cnt <= EDGE_MAX
      |=> !offfreq_o && !inact_o)
      else $error("in-range reference still alarmed");

endmodule
`default_nettype wire

// File: tdm_reference_selection.sv
// reference selection and protection switching for two timing paths
`timescale 1ns/1ps
`default_nettype none
module tdm_reference_selection #(
   parameter int WIN_10M = refsel_pkg::WIN_CYC_10M,
   parameter int WIN_12M8 = refsel_pkg::WIN_CYC_12M8,
   parameter int WIN_20M = refsel_pkg::WIN_CYC_20M
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic nrst_i,
   // reference clock pins
   input wire logic [refsel_pkg::NUM_REF-1:0] ref_clk_i,
   // host configuration
   input wire logic [1:0] osc_sel_i,
   input wire logic [refsel_pkg::NUM_PATH-1:0] tbl_load_i,
   input wire logic [refsel_pkg::TBL_W-1:0] tbl_data_i,
   input wire logic [refsel_pkg::NUM_PATH-1:0] holdover_req_i,
   input wire logic alert_clr_i,
   // per path status and loop control
   output logic [refsel_pkg::NUM_PATH-1:0][refsel_pkg::REF_W-1:0] sel_ref_o,
   output logic [refsel_pkg::NUM_PATH-1:0] locked_o,
   output logic [refsel_pkg::NUM_PATH-1:0] holdover_o,
   output logic [refsel_pkg::NUM_PATH-1:0] noref_o,
   output logic [refsel_pkg::NUM_PATH-1:0] pbo_req_o,
   output logic [refsel_pkg::NUM_PATH-1:0][refsel_pkg::BW_W-1:0] loop_bw_o,
   output logic [refsel_pkg::NUM_PATH-1:0][refsel_pkg::NUM_REF-1:0]
      excluded_o,
   // monitor results and host alert
   output logic [refsel_pkg::NUM_REF-1:0] alarm_inact_o,
   output logic [refsel_pkg::NUM_REF-1:0] alarm_offfreq_o,
   output logic alert_o
);
   import refsel_pkg::*;

   // ****************************************
   // measurement window
   // ****************************************
   logic [WIN_W-1:0] win_cnt, next_win_cnt, win_last;
   logic win_tick, next_win_tick;

   always_comb begin
      case (osc_sel_i)
         OSC_12M8: win_last = WIN_W'(WIN_12M8 - 1);
         OSC_20M: win_last = WIN_W'(WIN_20M - 1);
         default: win_last = WIN_W'(WIN_10M - 1);
      endcase
      next_win_tick = (win_cnt >= win_last);
      next_win_cnt = next_win_tick ? '0 : win_cnt + WIN_W'(1);
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         win_cnt <= '0;
         win_tick <= 1'b0;
      end else begin
         win_cnt <= next_win_cnt;
         win_tick <= next_win_tick;
      end
   end

   // ****************************************
   // reference monitors
   // ****************************************
   logic [NUM_REF-1:0] alarm;

   for (genvar i = 0; i < NUM_REF; i++) begin : g_mon
      ref_monitor u_mon (
         .clk_i(clk_i),
         .nrst_i(nrst_i),
         .ref_i(ref_clk_i[i]),
         .win_tick_i(win_tick),
         .inact_o(alarm_inact_o[i]),
         .offfreq_o(alarm_offfreq_o[i])
      );
   end

   assign alarm = alarm_inact_o | alarm_offfreq_o;

   // ****************************************
   // candidate decode per path
   // ****************************************
   logic [NUM_PATH-1:0][TBL_W-1:0] tbl, next_tbl;
   logic [NUM_PATH-1:0][NUM_REF-1:0] excl, next_excl;
   logic [NUM_PATH-1:0][REF_W:0] pick;
   logic [NUM_PATH-1:0][NUM_REF-1:0] hit;

   // excluded and alarmed references never count as qualified
   always_comb begin
      for (int p = 0; p < NUM_PATH; p++) begin
         pick[p] = pick_ref(tbl[p], excl[p] | alarm);
         hit[p] = alarm & tbl_members(tbl[p]) & ~excl[p];
      end
   end

   // ****************************************
   // path selection
   // ****************************************
   path_state_t state [NUM_PATH];
   path_state_t next_state [NUM_PATH];
   logic [NUM_PATH-1:0][REF_W-1:0] next_sel;
   logic [NUM_PATH-1:0] next_pbo, next_noref;
   logic next_alert;

   always_comb begin
      logic [NUM_REF-1:0] sel_mask;
      sel_mask = '0;
      next_alert = alert_o & ~alert_clr_i;
      for (int p = 0; p < NUM_PATH; p++) begin
         next_tbl[p] = tbl[p];
         next_state[p] = state[p];
         next_sel[p] = sel_ref_o[p];
         next_pbo[p] = 1'b0;
         next_noref[p] = !pick[p][REF_W];
         sel_mask = (state[p] == ST_EMPTY) ? '0 :
            (NUM_REF'(1) << sel_ref_o[p]);
         // a failed selected reference stays out until the host reloads,
         // so reversion waits on the host's wait-to-restore timing
         next_excl[p] = excl[p] | hit[p];
         if ((hit[p] & ~sel_mask) != '0) begin
            next_alert = 1'b1;
         end
         case (state[p])
            ST_EMPTY: begin
               if (pick[p][REF_W] && !holdover_req_i[p]) begin
                  next_state[p] = ST_LOCK;
                  next_sel[p] = pick[p][REF_W-1:0];
                  next_pbo[p] = 1'b1;
               end
            end
            ST_LOCK: begin
               if (holdover_req_i[p]) begin
                  next_state[p] = ST_HOLD;
               end else if (!pick[p][REF_W]) begin
                  next_state[p] = ST_HOLD;
               end else if (pick[p][REF_W-1:0] != sel_ref_o[p]) begin
                  next_sel[p] = pick[p][REF_W-1:0];
                  next_pbo[p] = 1'b1;
               end
            end
            ST_HOLD: begin
               if (!holdover_req_i[p] && pick[p][REF_W]) begin
                  next_state[p] = ST_LOCK;
                  next_sel[p] = pick[p][REF_W-1:0];
                  next_pbo[p] = 1'b1;
               end
            end
            default: begin
               next_state[p] = ST_EMPTY;
            end
         endcase
         if (tbl_load_i[p]) begin
            next_tbl[p] = tbl_data_i;
            next_excl[p] = EXCL_RST;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         for (int p = 0; p < NUM_PATH; p++) begin
            tbl[p] <= TBL_RST;
            excl[p] <= EXCL_RST;
            state[p] <= ST_EMPTY;
            sel_ref_o[p] <= SEL_RST;
            locked_o[p] <= 1'b0;
            holdover_o[p] <= 1'b0;
            noref_o[p] <= 1'b1;
            pbo_req_o[p] <= 1'b0;
            excluded_o[p] <= EXCL_RST;
         end
         loop_bw_o[PATH_EQ] <= BW_EQ_RST;
         loop_bw_o[PATH_ST] <= BW_ST_RST;
         alert_o <= 1'b0;
      end else begin
         for (int p = 0; p < NUM_PATH; p++) begin
            tbl[p] <= next_tbl[p];
            excl[p] <= next_excl[p];
            state[p] <= next_state[p];
            sel_ref_o[p] <= next_sel[p];
            locked_o[p] <= (next_state[p] == ST_LOCK);
            holdover_o[p] <= (next_state[p] == ST_HOLD);
            noref_o[p] <= next_noref[p];
            pbo_req_o[p] <= next_pbo[p];
            excluded_o[p] <= next_excl[p];
         end
         loop_bw_o[PATH_EQ] <= BW_EQ_RST;
         loop_bw_o[PATH_ST] <= BW_ST_RST;
         alert_o <= next_alert;
      end
   end

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!nrst_i);

   sequence eq_sel_fails;
      state[PATH_EQ] == ST_LOCK && !holdover_req_i[PATH_EQ]
      && alarm[sel_ref_o[PATH_EQ]] && pick[PATH_EQ][REF_W];
   endsequence

   sequence eq_moves_on;
      pbo_req_o[PATH_EQ] && locked_o[PATH_EQ]
      && sel_ref_o[PATH_EQ] != $past(sel_ref_o[PATH_EQ]);
   endsequence

   sequence st_sel_fails;
      state[PATH_ST] == ST_LOCK && !holdover_req_i[PATH_ST]
      && alarm[sel_ref_o[PATH_ST]] && pick[PATH_ST][REF_W];
   endsequence

   sequence st_moves_on;
      pbo_req_o[PATH_ST] && locked_o[PATH_ST]
      && sel_ref_o[PATH_ST] != $past(sel_ref_o[PATH_ST]);
   endsequence

   win_period_a: assert property (
      win_tick && osc_sel_i == OSC_10M && $stable(osc_sel_i)
      |-> ##1 !win_tick [*8])
      else $error("window strobe repeated too early");
   win_reload_a: assert property (
      win_tick |-> win_cnt == '0)
      else $error("window counter not restarted with strobe");
   eq_fail_switch_a: assert property (
      eq_sel_fails |=> eq_moves_on)
      else $error("failed equipment reference not switched away");
   nonsel_alert_a: assert property (
      (hit[PATH_ST] & ~(NUM_REF'(1) << sel_ref_o[PATH_ST])) != '0
      && !tbl_load_i[PATH_ST] |=> alert_o && excluded_o[PATH_ST] != '0)
      else $error("unselected failure not excluded and alerted");
   alert_set_wins_a: assert property (
      alert_clr_i && (hit[PATH_EQ] & ~(NUM_REF'(1) << sel_ref_o[PATH_EQ]))
      != '0 && state[PATH_EQ] != ST_EMPTY |=> alert_o)
      else $error("alert lost while being cleared");
   load_clears_a: assert property (
      tbl_load_i[PATH_EQ] |=> excluded_o[PATH_EQ] == '0
      && tbl[PATH_EQ] == $past(tbl_data_i))
      else $error("table load did not take effect");
   path_indep_a: assert property (
      tbl_load_i == 2'h1 |=> $stable(tbl[PATH_ST]))
      else $error("station table changed by equipment load");
   hold_freeze_a: assert property (
      holdover_o[PATH_EQ] && $past(holdover_o[PATH_EQ])
      |-> $stable(sel_ref_o[PATH_EQ]) && !pbo_req_o[PATH_EQ])
      else $error("reference moved during holdover");
   hold_enter_a: assert property (
      state[PATH_ST] == ST_LOCK && holdover_req_i[PATH_ST]
      |=> holdover_o[PATH_ST] && !locked_o[PATH_ST])
      else $error("holdover request not honoured");
   noref_hold_a: assert property (
      state[PATH_EQ] == ST_LOCK && !pick[PATH_EQ][REF_W]
      |=> holdover_o[PATH_EQ] && noref_o[PATH_EQ])
      else $error("empty table did not force holdover");
   st_fail_switch_a: assert property (
      st_sel_fails |=> st_moves_on)
      else $error("failed station reference not switched away");
   st_noref_hold_a: assert property (
      state[PATH_ST] == ST_LOCK && !pick[PATH_ST][REF_W]
      |=> holdover_o[PATH_ST] && noref_o[PATH_ST])
      else $error("empty station table did not force holdover");
   st_load_clears_a: assert property (
      tbl_load_i[PATH_ST] |=> excluded_o[PATH_ST] == '0
      && tbl[PATH_ST] == $past(tbl_data_i))
      else $error("station table load did not take effect");
   eq_indep_a: assert property (
      tbl_load_i == 2'h2 |=> $stable(tbl[PATH_EQ]))
      else $error("equipment table changed by station load");
   alert_sticky_a: assert property (
      alert_o && !alert_clr_i |=> alert_o)
      else $error("alert dropped without a clear");
   alert_clear_a: assert property (
      alert_clr_i && hit == '0 |=> !alert_o)
      else $error("alert not cleared");
   eq_hold_enter_a: assert property (
      state[PATH_EQ] == ST_LOCK && holdover_req_i[PATH_EQ]
      |=> holdover_o[PATH_EQ] && !locked_o[PATH_EQ])
      else $error("equipment holdover request not honoured");
   st_hold_freeze_a: assert property (
      holdover_o[PATH_ST] && $past(holdover_o[PATH_ST])
      |-> $stable(sel_ref_o[PATH_ST]) && !pbo_req_o[PATH_ST])
      else $error("station reference moved during holdover");
   excl_grows_a: assert property (
      !tbl_load_i[PATH_EQ] |=> (excluded_o[PATH_EQ]
      & $past(excluded_o[PATH_EQ])) == $past(excluded_o[PATH_EQ]))
      else $error("exclusion dropped without a table load");
   pbo_locked_a: assert property (
      pbo_req_o[PATH_EQ] |-> locked_o[PATH_EQ])
      else $error("build-out request outside tracking");

endmodule
`default_nettype wire

// File: ref_source.sv
// behavioural model of the four incoming reference clock sources
`timescale 1ns/1ps
`default_nettype none
module ref_source (
   // clock and reset
   input wire logic clk_i,
   input wire logic nrst_i,
   // per reference mode: 0 dead, 1 nominal, 2 fast
   input wire logic [7:0] mode_i,
   // reference pins
   output logic [3:0] ref_clk_o
);
   logic [3:0][2:0] cnt;
   logic [3:0][2:0] last;

   // nominal gives 8 edges per 40 cycle window, fast gives 20
   always_comb begin
      for (int r = 0; r < 4; r++) begin
         last[r] = (mode_i[2*r +: 2] == 2'h2) ? 3'h1 : 3'h4;
      end
   end

   always_ff @(posedge clk_i) begin
      for (int r = 0; r < 4; r++) begin
         if (!nrst_i || cnt[r] >= last[r]) begin
            cnt[r] <= 3'h0;
         end else begin
            cnt[r] <= cnt[r] + 3'h1;
         end
         // dead source stays low, no edges at all
         ref_clk_o[r] <= (mode_i[2*r +: 2] != 2'h0) && (cnt[r] == 3'h0);
      end
   end
endmodule
`default_nettype wire

// File: tb_tdm_reference_selection.sv
// self-checking testbench for tdm reference selection
`timescale 1ns/1ps
`default_nettype none
module tb_tdm_reference_selection;
   import refsel_pkg::*;

   // ****************************************
   // signals
   // ****************************************
   logic clk_i;
   logic nrst_i;
   logic [NUM_REF-1:0] ref_clk_i;
   logic [1:0] osc_sel_i;
   logic [NUM_PATH-1:0] tbl_load_i;
   logic [TBL_W-1:0] tbl_data_i;
   logic [NUM_PATH-1:0] holdover_req_i;
   logic alert_clr_i;
   logic [7:0] mode;
   logic [NUM_PATH-1:0][REF_W-1:0] sel_ref_o;
   logic [NUM_PATH-1:0] locked_o;
   logic [NUM_PATH-1:0] holdover_o;
   logic [NUM_PATH-1:0] noref_o;
   logic [NUM_PATH-1:0] pbo_req_o;
   logic [NUM_PATH-1:0][BW_W-1:0] loop_bw_o;
   logic [NUM_PATH-1:0][NUM_REF-1:0] excluded_o;
   logic [NUM_REF-1:0] alarm_inact_o;
   logic [NUM_REF-1:0] alarm_offfreq_o;
   logic alert_o;
   int n_fail;
   int comparisons;

   // short windows keep the run brief
   tdm_reference_selection #(.WIN_10M(40), .WIN_12M8(52), .WIN_20M(80)) DUT (
      .clk_i(clk_i), .nrst_i(nrst_i), .ref_clk_i(ref_clk_i),
      .osc_sel_i(osc_sel_i), .tbl_load_i(tbl_load_i),
      .tbl_data_i(tbl_data_i), .holdover_req_i(holdover_req_i),
      .alert_clr_i(alert_clr_i), .sel_ref_o(sel_ref_o),
      .locked_o(locked_o), .holdover_o(holdover_o), .noref_o(noref_o),
      .pbo_req_o(pbo_req_o), .loop_bw_o(loop_bw_o),
      .excluded_o(excluded_o), .alarm_inact_o(alarm_inact_o),
      .alarm_offfreq_o(alarm_offfreq_o), .alert_o(alert_o));

   ref_source src (.clk_i(clk_i), .nrst_i(nrst_i), .mode_i(mode),
      .ref_clk_o(ref_clk_i));

   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end

   // ****************************************
   // helpers
   // ****************************************
   task automatic check(input string what, input logic [15:0] seen,
      input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge clk_i);
   endtask

   task automatic test_done();
      $display("comparisons %0d n_fail %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // load at a falling edge; selection shows two rising edges later
   task automatic load(input int p, input logic [TBL_W-1:0] t);
      tbl_data_i = t;
      tbl_load_i[p] = 1'b1;
      @(negedge clk_i);
      tbl_load_i = '0;
   endtask

   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_reset();
      check("loop_bw eq", loop_bw_o[PATH_EQ], BW_EQ_RST);
      check("loop_bw st", loop_bw_o[PATH_ST], BW_ST_RST);
      check("noref", noref_o, 2'h3);
      check("locked", locked_o, 2'h0);
      check("alert", alert_o, 1'b0);
   endtask

   // eq ranks ref0, ref1, ref2; st ranks ref3, ref2
   task automatic t_tables();
      load(PATH_EQ, 12'h1AC);
      cyc(1);
      check("pbo eq", pbo_req_o[PATH_EQ], 1'b1);
      check("sel eq", sel_ref_o[PATH_EQ], 2'h0);
      load(PATH_ST, 12'h037);
      check("pbo eq gone", pbo_req_o[PATH_EQ], 1'b0);
      cyc(1);
      check("pbo st", pbo_req_o[PATH_ST], 1'b1);
      cyc(1);
      check("sel st", sel_ref_o[PATH_ST], 2'h3);
      check("locked both", locked_o, 2'h3);
   endtask

   task automatic t_kill_selected();
      mode[1:0] = 2'h0;
      cyc(120);
      check("inact", alarm_inact_o, 4'h1);
      check("sel eq next", sel_ref_o[PATH_EQ], 2'h1);
      check("excl eq", excluded_o[PATH_EQ], 4'h1);
      check("sel st kept", sel_ref_o[PATH_ST], 2'h3);
      check("no alert", alert_o, 1'b0);
   endtask

   task automatic t_offfreq_standby();
      mode[5:4] = 2'h2;
      // clear lands on the very edge that raises the new alert
      cyc(36);
      alert_clr_i = 1'b1;
      cyc(1);
      alert_clr_i = 1'b0;
      check("alert set wins", alert_o, 1'b1);
      cyc(83);
      check("offfreq", alarm_offfreq_o, 4'h4);
      check("excl eq", excluded_o[PATH_EQ], 4'h5);
      check("excl st", excluded_o[PATH_ST], 4'h4);
      check("alert", alert_o, 1'b1);
      check("sel eq held", sel_ref_o[PATH_EQ], 2'h1);
      alert_clr_i = 1'b1;
      cyc(1);
      alert_clr_i = 1'b0;
      check("alert cleared", alert_o, 1'b0);
   endtask

   task automatic t_host_holdover();
      holdover_req_i[PATH_ST] = 1'b1;
      cyc(2);
      check("hold st", holdover_o[PATH_ST], 1'b1);
      check("sel st frozen", sel_ref_o[PATH_ST], 2'h3);
      check("eq untouched", locked_o[PATH_EQ], 1'b1);
      holdover_req_i[PATH_ST] = 1'b0;
      cyc(3);
      check("relock st", locked_o[PATH_ST], 1'b1);
      check("hold st off", holdover_o[PATH_ST], 1'b0);
   endtask

   task automatic t_no_ref_left();
      mode[3:2] = 2'h0;
      cyc(120);
      check("hold eq", holdover_o[PATH_EQ], 1'b1);
      check("noref eq", noref_o, 2'h1);
      load(PATH_EQ, 12'h007);
      cyc(2);
      check("excl cleared", excluded_o[PATH_EQ], 4'h0);
      check("sel eq new", sel_ref_o[PATH_EQ], 2'h3);
      check("locked eq", locked_o, 2'h3);
   endtask

   // 80 cycle window turns nominal refs into 16 edges
   task automatic t_osc_rate();
      osc_sel_i = OSC_20M;
      cyc(300);
      check("offfreq 20M", alarm_offfreq_o, 4'hC);
      check("inact 20M", alarm_inact_o, 4'h3);
      check("hold both", holdover_o, 2'h3);
   endtask

   // a promoted standby unit starts from reset and is reloaded
   task automatic t_rerun();
      nrst_i = 1'b0;
      cyc(3);
      check("sel reset", sel_ref_o, 4'h0);
      check("locked reset", locked_o, 2'h0);
      check("hold reset", holdover_o, 2'h0);
      check("noref reset", noref_o, 2'h3);
      check("excl reset", excluded_o, 8'h00);
      check("alarms reset", {alarm_inact_o, alarm_offfreq_o}, 8'h00);
      check("alert reset", alert_o, 1'b0);
      nrst_i = 1'b1;
      load(PATH_EQ, 12'h007);
      cyc(1);
      check("relock eq", locked_o, 2'h1);
      check("sel eq again", sel_ref_o[PATH_EQ], 2'h3);
      check("pbo eq again", pbo_req_o, 2'h1);
   endtask

   // ****************************************
   // main sequence and watchdog
   // ****************************************
   initial begin
      n_fail = 0;
      comparisons = 0;
      nrst_i = 1'b0;
      osc_sel_i = OSC_10M;
      tbl_load_i = '0;
      tbl_data_i = TBL_RST;
      holdover_req_i = '0;
      alert_clr_i = 1'b0;
      mode = 8'h55;
      cyc(20);
      t_reset();
      nrst_i = 1'b1;
      t_tables();
      t_kill_selected();
      t_offfreq_standby();
      t_host_holdover();
      t_no_ref_left();
      t_osc_rate();
      t_rerun();
      test_done();
   end

   // whole sequence is under 1000 cycles
   initial begin
      #500000;
      n_fail++;
      test_done();
   end
endmodule
`default_nettype wire
